// [core/irq_reset_pkg.sv]
// constants shared by the interrupt and reset sequencer
package irq_reset_pkg;
	// ----------------------------------------------------------------
	// vector locations, high byte first
	// ----------------------------------------------------------------
	localparam logic [15:0] VEC_RESET  = 16'hFFFE;
	localparam logic [15:0] VEC_NMI    = 16'hFFFC;
	localparam logic [15:0] VEC_TRAP   = 16'hFFFA;
	localparam logic [15:0] VEC_EXT    = 16'hFFF8;
	localparam logic [15:0] VEC_ICAP   = 16'hFFF6;
	localparam logic [15:0] VEC_OCMP   = 16'hFFF4;
	localparam logic [15:0] VEC_TOVF   = 16'hFFF2;
	localparam logic [15:0] VEC_SERIAL = 16'hFFF0;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_VECTOR = 8'h08;
	localparam logic [7:0] OFS_MASK   = 8'h0C;

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_ICAP_EN   = 0;
	localparam int CTRL_OCMP_EN   = 1;
	localparam int CTRL_TOVF_EN   = 2;
	localparam int CTRL_RX_EN     = 3;
	localparam int CTRL_TX_EN     = 4;
	localparam int CTRL_STROBE_EN = 5;
	localparam int CTRL_W         = 6;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

	// mask register write fields
	localparam int MASK_CLR_BIT = 0;
	localparam int MASK_SET_BIT = 1;

	// condition code position of the interrupt mask
	localparam int CCR_I_BIT = 4;

	// ----------------------------------------------------------------
	// timing and sequencing
	// ----------------------------------------------------------------
	localparam int          E_DIV       = 4;
	localparam logic [2:0]  STACK_BYTES = 3'h7;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_DECERR = 2'h3;

	typedef enum logic [5:0] {
		ST_RESET = 6'b000001,
		ST_IDLE  = 6'b000010,
		ST_PUSH  = 6'b000100,
		ST_VHI   = 6'b001000,
		ST_VLO   = 6'b010000,
		ST_LOAD  = 6'b100000
	} seq_state_e;
endpackage

// [core/irq_reset_unit.sv]
// interrupt prioritising, state stacking, vector fetch and reset start-up
//
// Notes on behaviour
// - non-maskable request always taken, but only at an instruction boundary.
// - mask flag gates all maskable requests; per-source enables qualify all but the external pin.
// - timer and serial feed internal line; external pin and strobe feed external line.
// - external maskable line served before internal line when both pend.
// - internal line resolved by fixed priority over three timer and one serial source.
// - any non-reset interrupt stacks PC, X, A, B and condition codes.
// - after stacking fetch winning vector, then set mask and load PC, resume.
// - non-maskable vector at FFFC high, FFFD low.
// - external and strobe vector at FFF8 high, FFF9 low.
// - software trap vector at FFFA high, FFFB low.
// - capture FFF6, compare FFF4, overflow FFF2, serial FFF0.
// - serial vector raised by receive full, overrun/framing, or transmit empty.
// - falling edge on non-maskable input starts sequence; source holds it one E cycle.
// - external maskable input is level sensitive, taken only with mask clear.
// - on reset release all high address lines driven high.
// - on reset release the three mode pins are captured.
// - leaving reset loads PC from FFFE/FFFF and sets the mask.
// - bus-phase clock is the input clock divided by four.
`timescale 1ns/10ps
module irq_reset_unit
	import irq_reset_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	// axi4-lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// request sources
	input  wire logic              nmiN,
	input  wire logic              externalMaskableRequestN,
	input  wire logic              portInputStrobeFlag,
	input  wire logic              inputCaptureFlag,
	input  wire logic              outputCompareFlag,
	input  wire logic              timerOverflowFlag,
	input  wire logic              receiveFullFlag,
	input  wire logic              overrunFramingFlag,
	input  wire logic              transmitEmptyFlag,
	// core side
	input  wire logic              instrDone,
	input  wire logic              softwareTrap,
	input  wire logic              maskClearReq,
	input  wire logic              maskSetReq,
	input  wire logic [2:0]        modePins,
	input  wire logic [15:0]       pcIn,
	input  wire logic [15:0]       xIn,
	input  wire logic [7:0]        accAIn,
	input  wire logic [7:0]        accBIn,
	input  wire logic [7:0]        ccrIn,
	input  wire logic [15:0]       spIn,
	// memory port
	output logic                   memReq,
	output logic                   memWe,
	output logic [15:0]            memAddr,
	output logic [7:0]             memWdata,
	input  wire logic              memAck,
	input  wire logic [7:0]        memRdata,
	// results
	output logic                   eClk,
	output logic                   seqBusy,
	output logic                   pcLoad,
	output logic [15:0]            pcOut,
	output logic                   spLoad,
	output logic [15:0]            spOut,
	output logic                   interruptMask,
	output logic [2:0]             modeBits,
	output logic [7:0]             addrHigh
);
	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic isOffset(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		isOffset = (a == ADDR_W'(ofs));
	endfunction

	function automatic logic [7:0] stackByte(input logic [2:0] idx, input logic [15:0] pc,
		input logic [15:0] x, input logic [7:0] a, input logic [7:0] b, input logic [7:0] ccr);
		case (idx)
			3'h0: stackByte = pc[7:0];
			3'h1: stackByte = pc[15:8];
			3'h2: stackByte = x[7:0];
			3'h3: stackByte = x[15:8];
			3'h4: stackByte = a;
			3'h5: stackByte = b;
			default: stackByte = ccr;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	seq_state_e              stateFf;
	logic                    seqBusyFf;
	logic [1:0]              eCntFf;
	logic                    eClkFf;
	logic                    eTick;
	logic                    nmiPrevFf;
	logic                    nmiPendFf;
	logic                    iMaskFf;
	logic [CTRL_W-1:0]       ctrlFf;
	logic [2:0]              modeFf;
	logic                    modeTakenFf;
	logic [7:0]              addrHighFf;
	logic [2:0]              idxFf;
	logic [15:0]             vecBaseFf;
	logic [15:0]             vecLastFf;
	logic [7:0]              vecHiFf;
	logic                    fromResetFf;
	logic                    memReqFf;
	logic                    memWeFf;
	logic [15:0]             memAddrFf;
	logic [7:0]              memWdataFf;
	logic                    pcLoadFf;
	logic [15:0]             pcOutFf;
	logic                    spLoadFf;
	logic [15:0]             spOutFf;
	logic [15:0]             spBaseFf;
	logic [15:0]             pcSaveFf;
	logic [15:0]             xSaveFf;
	logic [7:0]              aSaveFf;
	logic [7:0]              bSaveFf;
	logic [7:0]              ccrSaveFf;
	logic                    extReq;
	logic                    serialReq;
	logic [3:0]              internalReq;
	logic                    anyReq;
	logic                    takeNow;
	logic [15:0]             nxt_vecBase;
	logic                    awreadyFf;
	logic                    wreadyFf;
	logic                    bvalidFf;
	logic [1:0]              brespFf;
	logic                    arreadyFf;
	logic                    rvalidFf;
	logic [31:0]             rdataFf;
	logic [1:0]              rrespFf;
	logic                    wrFire;
	logic                    rdFire;
	logic [31:0]             nxt_rdata;

	// ----------------------------------------------------------------
	// bus-phase clock
	// ----------------------------------------------------------------
	assign eTick = (eCntFf == 2'(E_DIV - 1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			eCntFf <= 2'h0;
			eClkFf <= 1'b0;
		end else begin
			eCntFf <= eCntFf + 2'h1;
			eClkFf <= (eCntFf == 2'h1) || (eCntFf == 2'h2);
		end
	end

	// ----------------------------------------------------------------
	// request collection and priority
	// ----------------------------------------------------------------
	assign extReq    = !externalMaskableRequestN ||
		(portInputStrobeFlag && ctrlFf[CTRL_STROBE_EN]);
	assign serialReq = ((receiveFullFlag || overrunFramingFlag) && ctrlFf[CTRL_RX_EN]) ||
		(transmitEmptyFlag && ctrlFf[CTRL_TX_EN]);
	assign internalReq = {inputCaptureFlag && ctrlFf[CTRL_ICAP_EN],
		outputCompareFlag && ctrlFf[CTRL_OCMP_EN],
		timerOverflowFlag && ctrlFf[CTRL_TOVF_EN], serialReq};
	assign anyReq  = nmiPendFf || softwareTrap || (!iMaskFf && (extReq || |internalReq));
	assign takeNow = (stateFf == ST_IDLE) && instrDone && anyReq;

	always_comb begin
		nxt_vecBase = VEC_SERIAL;
		if (nmiPendFf)
			nxt_vecBase = VEC_NMI;
		else if (softwareTrap)
			nxt_vecBase = VEC_TRAP;
		else if (extReq)
			nxt_vecBase = VEC_EXT;
		else if (internalReq[3])
			nxt_vecBase = VEC_ICAP;
		else if (internalReq[2])
			nxt_vecBase = VEC_OCMP;
		else if (internalReq[1])
			nxt_vecBase = VEC_TOVF;
	end

	// ----------------------------------------------------------------
	// non-maskable edge capture
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nmiPrevFf <= 1'b1;
			nmiPendFf <= 1'b0;
		end else begin
			nmiPrevFf <= nmiN;
			if (nmiPrevFf && !nmiN)
				nmiPendFf <= 1'b1;
			else if (takeNow && (nxt_vecBase == VEC_NMI))
				nmiPendFf <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// interrupt mask
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			iMaskFf <= 1'b1;
		end else if ((stateFf == ST_LOAD) || maskSetReq ||
			(wrFire && isOffset(s_axi_awaddr, OFS_MASK) && s_axi_wstrb[0] &&
			s_axi_wdata[MASK_SET_BIT])) begin
			iMaskFf <= 1'b1;
		end else if (maskClearReq || (wrFire && isOffset(s_axi_awaddr, OFS_MASK) &&
			s_axi_wstrb[0] && s_axi_wdata[MASK_CLR_BIT])) begin
			iMaskFf <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// mode capture and address lines
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			modeFf      <= 3'h0;
			modeTakenFf <= 1'b0;
		end else if (!modeTakenFf) begin
			modeFf      <= modePins;
			modeTakenFf <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			addrHighFf <= 8'hFF;
		else if (memReqFf)
			addrHighFf <= memAddrFf[15:8];
		else if (stateFf == ST_RESET)
			addrHighFf <= 8'hFF;
	end

	// ----------------------------------------------------------------
	// sequencer and memory port
	// ----------------------------------------------------------------
	// busy follows the next state so the port leaves a flip-flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			seqBusyFf <= 1'b1;
		else
			seqBusyFf <= !((stateFf == ST_LOAD) || ((stateFf == ST_IDLE) && !takeNow));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stateFf     <= ST_RESET;
			idxFf       <= 3'h0;
			vecBaseFf   <= VEC_RESET;
			vecLastFf   <= VEC_RESET;
			vecHiFf     <= 8'h00;
			fromResetFf <= 1'b1;
			memReqFf    <= 1'b0;
			memWeFf     <= 1'b0;
			memAddrFf   <= 16'hFFFF;
			memWdataFf  <= 8'h00;
			pcLoadFf    <= 1'b0;
			pcOutFf     <= 16'h0000;
			spLoadFf    <= 1'b0;
			spOutFf     <= 16'h0000;
			spBaseFf    <= 16'h0000;
			pcSaveFf    <= 16'h0000;
			xSaveFf     <= 16'h0000;
			aSaveFf     <= 8'h00;
			bSaveFf     <= 8'h00;
			ccrSaveFf   <= 8'h00;
		end else begin
			pcLoadFf <= 1'b0;
			spLoadFf <= 1'b0;
			case (stateFf)
				ST_RESET: begin
					vecBaseFf   <= VEC_RESET;
					fromResetFf <= 1'b1;
					stateFf     <= ST_VHI;
				end
				ST_IDLE: begin
					if (takeNow) begin
						vecBaseFf   <= nxt_vecBase;
						fromResetFf <= 1'b0;
						idxFf       <= 3'h0;
						spBaseFf    <= spIn;
						pcSaveFf    <= pcIn;
						xSaveFf     <= xIn;
						aSaveFf     <= accAIn;
						bSaveFf     <= accBIn;
						ccrSaveFf   <= ccrIn;
						ccrSaveFf[CCR_I_BIT] <= iMaskFf;
						stateFf     <= ST_PUSH;
					end
				end
				ST_PUSH: begin
					if (memReqFf && memAck) begin
						memReqFf <= 1'b0;
						memWeFf  <= 1'b0;
						idxFf    <= idxFf + 3'h1;
						if (idxFf == STACK_BYTES - 3'h1)
							stateFf <= ST_VHI;
					end else if (!memReqFf && eTick) begin
						memReqFf   <= 1'b1;
						memWeFf    <= 1'b1;
						memAddrFf  <= spBaseFf - 16'(idxFf);
						memWdataFf <= stackByte(idxFf, pcSaveFf, xSaveFf, aSaveFf,
							bSaveFf, ccrSaveFf);
					end
				end
				ST_VHI: begin
					if (memReqFf && memAck) begin
						memReqFf <= 1'b0;
						vecHiFf  <= memRdata;
						stateFf  <= ST_VLO;
					end else if (!memReqFf && eTick) begin
						memReqFf  <= 1'b1;
						memWeFf   <= 1'b0;
						memAddrFf <= vecBaseFf;
					end
				end
				ST_VLO: begin
					if (memReqFf && memAck) begin
						memReqFf <= 1'b0;
						pcOutFf  <= {vecHiFf, memRdata};
						stateFf  <= ST_LOAD;
					end else if (!memReqFf && eTick) begin
						memReqFf  <= 1'b1;
						memWeFf   <= 1'b0;
						memAddrFf <= vecBaseFf + 16'h0001;
					end
				end
				ST_LOAD: begin
					pcLoadFf  <= 1'b1;
					vecLastFf <= vecBaseFf;
					if (!fromResetFf) begin
						spLoadFf <= 1'b1;
						spOutFf  <= spBaseFf - 16'(STACK_BYTES);
					end
					stateFf <= ST_IDLE;
				end
				default: stateFf <= ST_RESET;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	assign wrFire = s_axi_awvalid && awreadyFf && s_axi_wvalid && wreadyFf;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awreadyFf <= 1'b0;
			wreadyFf  <= 1'b0;
			bvalidFf  <= 1'b0;
			brespFf   <= RESP_OKAY;
		end else begin
			if (wrFire) begin
				awreadyFf <= 1'b0;
				wreadyFf  <= 1'b0;
				bvalidFf  <= 1'b1;
				brespFf   <= (isOffset(s_axi_awaddr, OFS_CTRL) || isOffset(s_axi_awaddr,
					OFS_MASK) || isOffset(s_axi_awaddr, OFS_STATUS) ||
					isOffset(s_axi_awaddr, OFS_VECTOR)) ? RESP_OKAY : RESP_DECERR;
			end else if (!bvalidFf && s_axi_awvalid && s_axi_wvalid) begin
				awreadyFf <= 1'b1;
				wreadyFf  <= 1'b1;
			end
			if (bvalidFf && s_axi_bready)
				bvalidFf <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ctrlFf <= CTRL_RESET;
		else if (wrFire && isOffset(s_axi_awaddr, OFS_CTRL) && s_axi_wstrb[0])
			ctrlFf <= s_axi_wdata[CTRL_W-1:0];
	end

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	assign rdFire = s_axi_arvalid && arreadyFf;

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (isOffset(s_axi_araddr, OFS_CTRL))
			nxt_rdata[CTRL_W-1:0] = ctrlFf;
		else if (isOffset(s_axi_araddr, OFS_STATUS))
			nxt_rdata[25:0] = {modeFf, nmiPendFf, extReq, internalReq, iMaskFf,
				8'h00, 2'h0, stateFf};
		else if (isOffset(s_axi_araddr, OFS_VECTOR))
			nxt_rdata[15:0] = vecLastFf;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arreadyFf <= 1'b0;
			rvalidFf  <= 1'b0;
			rdataFf   <= 32'h0000_0000;
			rrespFf   <= RESP_OKAY;
		end else begin
			if (rdFire) begin
				arreadyFf <= 1'b0;
				rvalidFf  <= 1'b1;
				rdataFf   <= nxt_rdata;
				rrespFf   <= (isOffset(s_axi_araddr, OFS_CTRL) || isOffset(s_axi_araddr,
					OFS_STATUS) || isOffset(s_axi_araddr, OFS_VECTOR) ||
					isOffset(s_axi_araddr, OFS_MASK)) ? RESP_OKAY : RESP_DECERR;
			end else if (!rvalidFf && s_axi_arvalid) begin
				arreadyFf <= 1'b1;
			end
			if (rvalidFf && s_axi_rready)
				rvalidFf <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = awreadyFf;
	assign s_axi_wready  = wreadyFf;
	assign s_axi_bvalid  = bvalidFf;
	assign s_axi_bresp   = brespFf;
	assign s_axi_arready = arreadyFf;
	assign s_axi_rvalid  = rvalidFf;
	assign s_axi_rdata   = rdataFf;
	assign s_axi_rresp   = rrespFf;
	assign memReq        = memReqFf;
	assign memWe         = memWeFf;
	assign memAddr       = memAddrFf;
	assign memWdata      = memWdataFf;
	assign eClk          = eClkFf;
	assign seqBusy       = seqBusyFf;
	assign pcLoad        = pcLoadFf;
	assign pcOut         = pcOutFf;
	assign spLoad        = spLoadFf;
	assign spOut         = spOutFf;
	assign interruptMask = iMaskFf;
	assign modeBits      = modeFf;
	assign addrHigh      = addrHighFf;
endmodule

// [verif/irq_reset_unit_bench.sv]
// self-checking bench for the interrupt and reset sequencer
`timescale 1ns/10ps
module irq_reset_unit_bench;
	import irq_reset_pkg::*;
	logic        clk, rst_n, nmiN, externalMaskableRequestN, instrDone, softwareTrap;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        maskClearReq, maskSetReq, slow, memReq, memWe, memAck, eClk, seqBusy;
	logic        pcLoad, spLoad, interruptMask;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, accAIn, accBIn, ccrIn, memWdata, memRdata, addrHigh;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [6:0]  fl;
	logic [2:0]  modePins, modeBits;
	logic [15:0] pcIn, xIn, spIn, memAddr, pcOut, spOut;
	logic [6:0]  tf[7] = '{7'h3C, 7'h1C, 7'h0C, 7'h04, 7'h02, 7'h01, 7'h40};
	logic [15:0] tv[7] = '{VEC_ICAP, VEC_OCMP, VEC_TOVF, VEC_SERIAL, VEC_SERIAL, VEC_SERIAL, VEC_EXT};
	int          n_errors = 0, comparisons = 0, k = 0;

	irq_reset_unit uut (
		.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nmiN, .externalMaskableRequestN,
		.portInputStrobeFlag(fl[6]), .inputCaptureFlag(fl[5]), .outputCompareFlag(fl[4]),
		.timerOverflowFlag(fl[3]), .receiveFullFlag(fl[2]), .overrunFramingFlag(fl[1]),
		.transmitEmptyFlag(fl[0]), .instrDone, .softwareTrap, .maskClearReq, .maskSetReq,
		.modePins, .pcIn, .xIn, .accAIn, .accBIn, .ccrIn, .spIn, .memReq, .memWe, .memAddr,
		.memWdata, .memAck, .memRdata, .eClk, .seqBusy, .pcLoad, .pcOut, .spLoad, .spOut,
		.interruptMask, .modeBits, .addrHigh
	);
	vector_mem_model mem (
		.clk, .rst_n, .slow, .memReq, .memWe, .memAddr, .memWdata, .memAck, .memRdata
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		results();
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic results();
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		comparisons++;
		if (g !== x) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", s, x, g);
		end
	endtask
	function automatic logic [15:0] vec(input logic [15:0] a);
		return {a[7:0] ^ 8'h5A, (a[7:0] + 8'h01) ^ 8'h5A};
	endfunction
	task automatic axi(input logic we, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		if (we) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= wd;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			do begin
				@(posedge clk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
			end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
			while (!s_axi_bvalid) @(posedge clk);
			r = s_axi_bresp;
			s_axi_bready <= 1'b0;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do @(posedge clk); while (!s_axi_arready);
			s_axi_arvalid <= 1'b0;
			while (!s_axi_rvalid) @(posedge clk);
			d = s_axi_rdata;
			r = s_axi_rresp;
			s_axi_rready <= 1'b0;
		end
	endtask
	task automatic clr();
		@(posedge clk);
		maskClearReq <= 1'b1;
		@(posedge clk);
		maskClearReq <= 1'b0;
		@(posedge clk);
	endtask
	task automatic quiet();
		@(posedge clk);
		instrDone <= 1'b1;
		@(posedge clk);
		instrDone <= 1'b0;
		repeat (20) @(posedge clk);
		chk("busy", 1'b0, seqBusy);
	endtask
	task automatic irq(input logic [15:0] v, input logic mb, input logic trap);
		logic [7:0] e[7];
		k++;
		mem.wlog.delete();
		pcIn <= 16'h1200 + 16'(k);
		xIn <= 16'h5600 + 16'(k);
		spIn <= 16'h0100 + 16'(k);
		{accAIn, accBIn, ccrIn} <= {8'(k), ~8'(k), 8'(k) ^ 8'h0F};
		if (!mb) clr();
		@(posedge clk);
		instrDone <= 1'b1;
		softwareTrap <= trap;
		@(posedge clk);
		instrDone <= 1'b0;
		softwareTrap <= 1'b0;
		repeat (400) if (!pcLoad) @(posedge clk);
		e = '{pcIn[7:0], pcIn[15:8], xIn[7:0], xIn[15:8], accAIn, accBIn, ccrIn};
		e[6][CCR_I_BIT] = mb;
		chk("pc", vec(v), pcOut);
		chk("sp", spIn - 16'h7, spOut);
		chk("spLoad", 1'b1, spLoad);
		chk("pushes", 7, mem.wlog.size());
		for (int i = 0; i < 7; i++) chk("push", {spIn - 16'(i), e[i]}, mem.wlog[i]);
		@(posedge clk);
		chk("mask", 1'b1, interruptMask);
		axi(1'b0, OFS_VECTOR, 0);
		chk("vector", v, d);
	endtask
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready, rst_n} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, fl, instrDone, softwareTrap} = '0;
		{maskClearReq, maskSetReq, slow, pcIn, xIn, accAIn, accBIn, ccrIn, spIn} = '0;
		{nmiN, externalMaskableRequestN, s_axi_wstrb, modePins} = {2'h3, 4'hF, 3'h5};
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("addrHigh", 8'hFF, addrHigh);
		repeat (300) if (!pcLoad) @(posedge clk);
		chk("resetPc", vec(VEC_RESET), pcOut);
		chk("resetSp", 1'b0, spLoad);
		chk("mask", 1'b1, interruptMask);
		chk("mode", 3'h5, modeBits);
		axi(1'b0, OFS_STATUS, 0);
		chk("status", 32'h0281_0002, d);
		modePins <= 3'h2;
		axi(1'b1, OFS_CTRL, 32'h3F);
		chk("ctrlResp", RESP_OKAY, r);
		axi(1'b0, OFS_CTRL, 0);
		chk("ctrl", 32'h3F, d);
		axi(1'b0, 8'h10, 0);
		chk("unmapped", RESP_DECERR, r);
		externalMaskableRequestN <= 1'b0;
		fl <= 7'h20;
		quiet();
		externalMaskableRequestN <= 1'b1;
		axi(1'b1, OFS_CTRL, 0);
		axi(1'b1, OFS_MASK, 32'h1);
		chk("maskClr", 1'b0, interruptMask);
		quiet();
		maskSetReq <= 1'b1;
		@(posedge clk);
		maskSetReq <= 1'b0;
		axi(1'b1, OFS_CTRL, 32'h3F);
		quiet();
		externalMaskableRequestN <= 1'b0;
		irq(VEC_EXT, 1'b0, 1'b0);
		externalMaskableRequestN <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			fl <= tf[i];
			slow <= i[0];
			irq(tv[i], 1'b0, 1'b0);
		end
		fl <= 7'h00;
		nmiN <= 1'b0;
		repeat (4) @(posedge clk);
		nmiN <= 1'b1;
		repeat (10) @(posedge clk);
		chk("busy", 1'b0, seqBusy);
		irq(VEC_NMI, 1'b1, 1'b0);
		irq(VEC_TRAP, 1'b1, 1'b1);
		chk("mode", 3'h5, modeBits);
		results();
	end
endmodule

// [verif/irq_reset_unit_monitor.sv]
// assertions on the interrupt and reset sequencer ports
`timescale 1ns/10ps
module irq_reset_unit_monitor (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        memReq,
	input wire logic        memWe,
	input wire logic [15:0] memAddr,
	input wire logic [7:0]  memWdata,
	input wire logic        memAck,
	input wire logic        eClk,
	input wire logic        seqBusy,
	input wire logic        pcLoad,
	input wire logic        spLoad,
	input wire logic        interruptMask,
	input wire logic [2:0]  modeBits,
	input wire logic [7:0]  addrHigh
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	property p_mem_hold;
		memReq && !memAck |=> memReq && $stable({memAddr, memWe, memWdata});
	endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("memory request not held");
	property p_busy;
		memReq |-> seqBusy;
	endproperty
	a_busy: assert property (p_busy) else $error("memory access while idle");
	property p_load_mask;
		pcLoad |=> interruptMask;
	endproperty
	a_load_mask: assert property (p_load_mask) else $error("mask clear after load");
	property p_vec_rd;
		memReq && !memWe |-> memAddr[15:4] == 12'hFFF;
	endproperty
	a_vec_rd: assert property (p_vec_rd) else $error("read off vector table");
	property p_rst_mask;
		$rose(rst_n) |-> interruptMask;
	endproperty
	a_rst_mask: assert property (p_rst_mask) else $error("mask clear at reset");
	property p_rst_addr;
		$rose(rst_n) |-> addrHigh == 8'hFF;
	endproperty
	a_rst_addr: assert property (p_rst_addr) else $error("high address not all ones");
	property p_eclk;
		$rose(eClk) |=> eClk ##1 !eClk ##1 !eClk ##1 eClk;
	endproperty
	a_eclk: assert property (p_eclk) else $error("bus clock not divide by four");
	property p_mode_keep;
		$past(rst_n, 2) |-> $stable(modeBits);
	endproperty
	a_mode_keep: assert property (p_mode_keep) else $error("mode bits changed");
	c_load: cover property (pcLoad && interruptMask);
	c_push: cover property (memAck && memWe);
	c_sp: cover property (spLoad);
endmodule

bind irq_reset_unit irq_reset_unit_monitor mon (
	.clk, .rst_n, .memReq, .memWe, .memAddr, .memWdata, .memAck, .eClk, .seqBusy,
	.pcLoad, .spLoad, .interruptMask, .modeBits, .addrHigh
);

// [verif/vector_mem_model.sv]
// memory partner answering stack writes and vector reads
`timescale 1ns/10ps
module vector_mem_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        slow,
	input  wire logic        memReq,
	input  wire logic        memWe,
	input  wire logic [15:0] memAddr,
	input  wire logic [7:0]  memWdata,
	output logic             memAck,
	output logic [7:0]       memRdata
);
	logic [23:0] wlog[$];
	logic [1:0]  waitCnt;
	// read data scrambles the address; between answers it toggles every cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			memAck <= 1'b0;
			waitCnt <= 2'h0;
			memRdata <= 8'h00;
		end else if (memReq && !memAck && waitCnt == (slow ? 2'h3 : 2'h0)) begin
			memAck <= 1'b1;
			waitCnt <= 2'h0;
			memRdata <= memAddr[7:0] ^ 8'h5A;
			if (memWe) wlog.push_back({memAddr, memWdata});
		end else begin
			memAck <= 1'b0;
			memRdata <= ~memRdata;
			if (memReq && !memAck) waitCnt <= waitCnt + 2'h1;
		end
	end
endmodule
